/* File: core/sarseq_ctrl.sv */
/*
 sarseq_ctrl: converter clocking, SAR trial sequence, channel sequencer,
 limit check and AXI4-Lite register slave.
 Assumes the comparator and low-power level arrive asynchronously.
*/
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sarseq_ctrl
  import sarseq_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic [AW-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [AW-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic COMP_IN,
  input wire logic LOWPOWER_IN,
  input wire logic [SW_W-1:0] SW_USER_IN,
  output logic [RES_W-1:0] DAC_CODE_OUT,
  output logic SAMPLE_OUT,
  output logic [4:0] CH_SEL_OUT,
  output logic [1:0] REF_SEL_OUT,
  output logic TEMP_EN_OUT,
  output logic [SW_W-1:0] SW_CTRL_OUT,
  output logic EOC_OUT,
  output logic IRQ_OUT
);
  sarseq_mem_if #(.W(RES_W), .D(NSLOT)) mif ();
  sarseq_mem #(.W(RES_W), .D(NSLOT)) u_mem (.clk_in(MCLK_IN), .bus(mif.mem));

  sarseq_state_e st_ff;
  logic [2:0] div_ff;
  logic conv_en;
  logic comp_m_ff, comp_s_ff, lp_m_ff, lp_s_ff;
  logic [8:0] ctrl_ff;
  logic [NSLOT-1:0] chen_ff, res_vld_ff;
  logic [4:0] fwch_ff, ch_ff;
  logic [RES_W-1:0] lo_ff, hi_ff, dac_ff, last_ff;
  logic [SW_W-1:0] swfw_ff;
  logic [7:0] samp_ff [NSLOT];
  logic [7:0] cnt_ff, samp_lim;
  logic oor_ff, start_ff, eoc_ff;
  logic aw_hold_ff, w_hold_ff, bvalid_ff, ar_busy_ff, rvalid_ff;
  logic [AW-1:0] awaddr_ff, araddr_ff;
  logic [31:0] wdata_ff, rdata_ff, rd_word, lim_word;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_fire, stop, res_oor, clr_oor;
  logic [5:0] nxt, first_ch;
  logic [NSLOT-1:0] mask;
  logic [11:0] bitm;

  // next enabled channel after cur, wrapping; bit 5 high when one exists
  function automatic logic [5:0] find_next(input logic [4:0] cur, input logic [NSLOT-1:0] m);
    logic [5:0] r;
    logic [4:0] k;
    r = 6'h00;
    for (int i = NSLOT; i >= 1; i--)
    begin
      k = 5'((32'(cur) + i) % NSLOT);
      if (m[k])
        r = {1'b1, k};
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  function automatic logic slot_ok(input logic [AW-1:0] a);
    return 32'(a[6:2]) < NSLOT;
  endfunction

  // converter clock enable, never above 18 MHz
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN || div_ff == 3'(CONV_DIV - 1))
      div_ff <= 3'h0;
    else
      div_ff <= div_ff + 3'h1;
  end
  assign conv_en = (div_ff == 3'(CONV_DIV - 1));

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      comp_m_ff <= 1'b0;
      comp_s_ff <= 1'b0;
      lp_m_ff <= 1'b0;
      lp_s_ff <= 1'b0;
    end
    else
    begin
      comp_m_ff <= COMP_IN;
      comp_s_ff <= comp_m_ff;
      lp_m_ff <= LOWPOWER_IN;
      lp_s_ff <= lp_m_ff;
    end
  end

  // upper eight channels only with expand set; temperature slot 16
  assign mask = chen_ff & {1'b1, {8{ctrl_ff[CTL_EXP16]}}, 8'hFF};
  assign nxt = find_next(ch_ff, mask);
  assign first_ch = find_next(TEMP_CH, mask);
  assign samp_lim = (samp_ff[ch_ff] == 8'h00) ? 8'h01 : samp_ff[ch_ff];
  // deep low power, or disable, aborts and blocks conversions
  assign stop = lp_s_ff || !ctrl_ff[CTL_EN];
  assign bitm = 12'h800 >> cnt_ff[3:0];
  // limit check on the finished code
  assign res_oor = (dac_ff < lo_ff) || (dac_ff > hi_ff);
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign lim_word = merge({4'h0, hi_ff, 4'h0, lo_ff}, wdata_ff, wstrb_ff);

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      st_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      ch_ff <= 5'h00;
      dac_ff <= 12'h000;
    end
    else if (conv_en)
    begin
      unique case (st_ff)
        S_IDLE:
        begin
          cnt_ff <= 8'h00;
          // autonomous scan or firmware channel
          // firmware slot beyond the sensor has no sample time, so it is refused
          if (start_ff && !stop && !ctrl_ff[CTL_AUTO] && 32'(fwch_ff) < NSLOT)
          begin
            ch_ff <= fwch_ff;
            st_ff <= S_SAMPLE;
          end
          else if (start_ff && !stop && ctrl_ff[CTL_AUTO] && first_ch[5])
          begin
            ch_ff <= first_ch[4:0];
            st_ff <= S_SAMPLE;
          end
        end
        S_SAMPLE:
        begin
          // aperture from the channel's own sample time
          if (stop)
            st_ff <= S_IDLE;
          else if (cnt_ff >= samp_lim - 8'h01)
          begin
            st_ff <= S_CONV;
            cnt_ff <= 8'h00;
            dac_ff <= 12'h800;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
        S_CONV:
        begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff < 8'(RES_W))
            dac_ff <= (comp_s_ff ? dac_ff : (dac_ff & ~bitm)) | (bitm >> 1);
          if (stop)
            st_ff <= S_IDLE;
          else if (cnt_ff == 8'(CONV_CLKS - 1))
          begin
            cnt_ff <= 8'h00;
            // next channel samples on the very next converter clock
            if (ctrl_ff[CTL_AUTO] && nxt[5] && (nxt[4:0] > ch_ff || ctrl_ff[CTL_CONT]))
            begin
              ch_ff <= nxt[4:0];
              st_ff <= S_SAMPLE;
            end
            else
              st_ff <= S_IDLE;
          end
        end
      endcase
    end
  end

  logic done;
  assign done = conv_en && st_ff == S_CONV && !stop && cnt_ff == 8'(CONV_CLKS - 1);

  // result lands in the channel's own slot
  assign mif.wr_en = done;
  assign mif.wr_addr = ch_ff;
  assign mif.wr_data = dac_ff;
  assign mif.rd_addr = S_AXI_ARADDR_IN[6:2];
  assign clr_oor = wr_fire && awaddr_ff == OFS_STATUS && wstrb_ff[0] && wdata_ff[ST_OOR];

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      oor_ff <= 1'b0;
      eoc_ff <= 1'b0;
      last_ff <= 12'h000;
    end
    else
    begin
      eoc_ff <= done;
      if (done)
        last_ff <= dac_ff;
      // sticky, a new event wins over the clear
      if (done && res_oor)
        oor_ff <= 1'b1;
      else if (clr_oor)
        oor_ff <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      res_vld_ff <= '0;
    else
      for (int i = 0; i < NSLOT; i++)
        if (done && ch_ff == 5'(i))
          res_vld_ff[i] <= 1'b1;
        // cleared as the read word is captured, so the reader still sees it set
        else if (ar_busy_ff && araddr_ff[8:7] == REG_RESULT && araddr_ff[6:2] == 5'(i))
          res_vld_ff[i] <= 1'b0;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      start_ff <= 1'b0;
    else if (wr_fire && awaddr_ff == OFS_CTRL && wstrb_ff[0] && wdata_ff[CTL_START])
      start_ff <= 1'b1;
    else if (conv_en && st_ff == S_IDLE)
      start_ff <= 1'b0;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl_ff <= 9'h000;
      chen_ff <= '0;
      fwch_ff <= 5'h00;
      lo_ff <= 12'h000;
      hi_ff <= LIM_HI_RST;
      swfw_ff <= '0;
    end
    else if (wr_fire)
    begin
      unique case (awaddr_ff)
        OFS_CTRL: ctrl_ff <= 9'(merge(32'(ctrl_ff), wdata_ff, wstrb_ff)) & ~(9'h001 << CTL_START);
        OFS_CHEN: chen_ff <= NSLOT'(merge(32'(chen_ff), wdata_ff, wstrb_ff));
        OFS_FWCH: fwch_ff <= 5'(merge(32'(fwch_ff), wdata_ff, wstrb_ff));
        OFS_LIMIT:
        begin
          lo_ff <= lim_word[RES_W-1:0];
          hi_ff <= lim_word[LIM_HI +: RES_W];
        end
        OFS_SWFW: swfw_ff <= SW_W'(merge(32'(swfw_ff), wdata_ff, wstrb_ff));
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSLOT; g++)
    begin : g_samp
      always_ff @(posedge MCLK_IN)
      begin
        if (!RESETN_IN)
          samp_ff[g] <= SAMPLE_RST;
        else if (wr_fire && awaddr_ff[8:7] == REG_SAMPLE && awaddr_ff[6:2] == 5'(g) && wstrb_ff[0])
          samp_ff[g] <= wdata_ff[7:0];
      end
    end
  endgenerate

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= {S_AXI_AWADDR_IN[AW-1:2], 2'b00};
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA_IN;
        wstrb_ff <= S_AXI_WSTRB_IN;
      end
      if (wr_fire)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (awaddr_ff <= OFS_SWFW && awaddr_ff != OFS_STATUS) || awaddr_ff == OFS_STATUS
                    || (awaddr_ff[8:7] == REG_SAMPLE && slot_ok(awaddr_ff)) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && S_AXI_BREADY_IN)
        bvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_AWREADY_OUT = !aw_hold_ff && !bvalid_ff;
  assign S_AXI_WREADY_OUT = !w_hold_ff && !bvalid_ff;
  assign S_AXI_BVALID_OUT = bvalid_ff;
  assign S_AXI_BRESP_OUT = bresp_ff;
  assign S_AXI_ARREADY_OUT = !ar_busy_ff && !rvalid_ff;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (araddr_ff[8:7] == REG_SAMPLE && slot_ok(araddr_ff))
      rd_word = {24'h0, samp_ff[araddr_ff[6:2]]};
    else if (araddr_ff[8:7] == REG_RESULT && slot_ok(araddr_ff))
      rd_word = {res_vld_ff[araddr_ff[6:2]], 19'h0, mif.rd_data};
    else
      unique case (araddr_ff)
        OFS_CTRL: rd_word = {23'h0, ctrl_ff};
        OFS_CHEN: rd_word = 32'(chen_ff);
        OFS_FWCH: rd_word = {27'h0, fwch_ff};
        OFS_LIMIT: rd_word = {4'h0, hi_ff, 4'h0, lo_ff};
        OFS_STATUS: rd_word = {24'h0, lp_s_ff, ch_ff, oor_ff, st_ff != S_IDLE};
        OFS_SWFW: rd_word = {24'h0, swfw_ff};
        OFS_LAST: rd_word = {20'h0, last_ff};
        default: rd_word = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      ar_busy_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      araddr_ff <= '0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
    begin
      ar_busy_ff <= 1'b1;
      araddr_ff <= {S_AXI_ARADDR_IN[AW-1:2], 2'b00};
    end
    else if (ar_busy_ff)
    begin
      ar_busy_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (araddr_ff <= OFS_LAST) || (araddr_ff[8] && slot_ok(araddr_ff)) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_ff && S_AXI_RREADY_IN)
      rvalid_ff <= 1'b0;
  end

  assign S_AXI_RVALID_OUT = rvalid_ff;
  assign S_AXI_RDATA_OUT = rdata_ff;
  assign S_AXI_RRESP_OUT = rresp_ff;

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      DAC_CODE_OUT <= 12'h000;
      SAMPLE_OUT <= 1'b0;
      CH_SEL_OUT <= 5'h00;
      REF_SEL_OUT <= REF_VDD;
      TEMP_EN_OUT <= 1'b0;
      SW_CTRL_OUT <= '0;
    end
    else
    begin
      DAC_CODE_OUT <= dac_ff;
      SAMPLE_OUT <= st_ff == S_SAMPLE;
      CH_SEL_OUT <= ch_ff;
      REF_SEL_OUT <= ctrl_ff[CTL_REF +: 2];
      // sensor bias only while its slot is in use
      TEMP_EN_OUT <= st_ff != S_IDLE && ch_ff == TEMP_CH;
      // sequencer, firmware and user logic share the switches
      SW_CTRL_OUT <= swfw_ff | SW_USER_IN
                     | ((ctrl_ff[CTL_SWSEQ] && st_ff != S_IDLE) ? SW_W'(8'h01 << ch_ff[2:0]) : '0);
    end
  end

  assign EOC_OUT = eoc_ff;
  // enable gates the sticky flag onto the line
  assign IRQ_OUT = oor_ff && ctrl_ff[CTL_OOR_IE];

  logic [7:0] conv_cyc_ff;
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN || st_ff != S_CONV)
      conv_cyc_ff <= 8'h00;
    else
      conv_cyc_ff <= conv_cyc_ff + 8'h01;
  end

  property p_div_gap;
    @(posedge MCLK_IN) disable iff (!RESETN_IN) conv_en |=> !conv_en [*6];
  endproperty
  a_div_gap: assert property (p_div_gap) else $error("converter enable too fast");
  sequence s_conv_exit;
    st_ff == S_CONV ##1 st_ff == S_SAMPLE;
  endsequence
  property p_conv_len;
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
      s_conv_exit |-> $past(conv_cyc_ff) == 8'd125;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion not 18 converter clocks");
  property p_no_gap;
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (done && ctrl_ff[CTL_AUTO] && nxt[5] && nxt[4:0] > ch_ff) |=> st_ff == S_SAMPLE;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("idle gap between channels");
  property p_lp_block;
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
      $past(lp_s_ff) && $past(conv_en) |-> !(st_ff == S_SAMPLE && $past(st_ff) == S_IDLE);
  endproperty
  a_lp_block: assert property (p_lp_block) else $error("start in low power");
  property p_oor_irq;
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (done && res_oor && ctrl_ff[CTL_OOR_IE]) |=> IRQ_OUT;
  endproperty
  a_oor_irq: assert property (p_oor_irq) else $error("out of range not flagged");
  property p_oor_sticky;
    @(posedge MCLK_IN) disable iff (!RESETN_IN) (oor_ff && !clr_oor) |=> oor_ff;
  endproperty
  a_oor_sticky: assert property (p_oor_sticky) else $error("flag dropped without clear");
  property p_ch_range;
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (st_ff != S_IDLE && ctrl_ff[CTL_AUTO] && !ctrl_ff[CTL_EXP16]) |-> (ch_ff < 5'h08 || ch_ff == TEMP_CH);
  endproperty
  a_ch_range: assert property (p_ch_range) else $error("channel beyond eight");
  property p_samp_len;
    @(posedge MCLK_IN) disable iff (!RESETN_IN) st_ff == S_SAMPLE |-> cnt_ff < samp_lim;
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sample time overrun");
  property p_slot_vld;
    @(posedge MCLK_IN) disable iff (!RESETN_IN) done |=> res_vld_ff[$past(ch_ff)];
  endproperty
  a_slot_vld: assert property (p_slot_vld) else $error("slot not marked");
endmodule // sarseq_ctrl

/* File: core/sarseq_mem.sv */
/*
 sarseq_mem: one result word per channel, read data registered.
 Assumes the controller holds rd_addr for one cycle before using rd_data.
*/
`timescale 1ns/1ps
module sarseq_mem #(parameter int W = 12, parameter int D = 17)
(
  input wire logic clk_in,
  sarseq_mem_if.mem bus
);
  logic [W-1:0] mem_ff [D];

  always_ff @(posedge clk_in)
  begin
    if (bus.wr_en)
      mem_ff[bus.wr_addr] <= bus.wr_data;
  end

  always_ff @(posedge clk_in)
  begin
    bus.rd_data <= mem_ff[bus.rd_addr];
  end
endmodule // sarseq_mem

/* File: core/sarseq_mem_if.sv */
/*
 sarseq_mem_if: write and read ports of the per-channel result store.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface sarseq_mem_if #(parameter int W = 12, parameter int D = 17);
  logic wr_en;
  logic [$clog2(D)-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [$clog2(D)-1:0] rd_addr;
  logic [W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: core/sarseq_pkg.sv */
/*
 sarseq_pkg: constants, register map and types of the converter sequencer.
 Assumes a single 125 MHz clock and an AXI4-Lite master on the register side.
*/
// Behaviour
// - results are 12 bits wide; sequencer sized for one conversion per microsecond class rates.
// - converter clock enable at most 18 MHz; every conversion spends 18 converter clocks.
// - reference select offers supply, half supply, internal 1.024 V and external pin.
// - sample-and-hold aperture length is programmable in converter clocks.
// - eight channels scanned, sixteen when the expand bit is set; firmware selection reaches all sixteen regardless.
// - enabled channels are scanned without software and with no idle cycles between.
// - channel switching chosen between autonomous scan and firmware-selected channel.
// - each channel keeps its own result word for later collection.
// - each channel has its own sample time applied when it is converted.
// - out-of-range results against low and high limits flag an interrupt at once.
// - the temperature sensor is an extra selectable converter input.
// - no conversion starts or continues while deep low-power mode is signalled.
// - sequencer drives routing switch controls together with firmware and user logic.
package sarseq_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CONV_MAX_HZ = 18_000_000;
  localparam int unsigned CONV_DIV = (CLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
  localparam int unsigned CONV_CLKS = 18;
  localparam int unsigned RES_W = 12;
  localparam int unsigned NSLOT = 17;
  localparam logic [4:0] TEMP_CH = 5'h10;
  localparam int unsigned SW_W = 8;
  localparam int unsigned AW = 9;
  localparam logic [8:0] OFS_CTRL = 9'h000;
  localparam logic [8:0] OFS_CHEN = 9'h004;
  localparam logic [8:0] OFS_FWCH = 9'h008;
  localparam logic [8:0] OFS_LIMIT = 9'h00C;
  localparam logic [8:0] OFS_STATUS = 9'h010;
  localparam logic [8:0] OFS_SWFW = 9'h014;
  localparam logic [8:0] OFS_LAST = 9'h018;
  localparam logic [1:0] REG_SAMPLE = 2'h2;
  localparam logic [1:0] REG_RESULT = 2'h3;
  localparam int CTL_EN = 0;
  localparam int CTL_AUTO = 1;
  localparam int CTL_START = 2;
  localparam int CTL_REF = 3;
  localparam int CTL_EXP16 = 5;
  localparam int CTL_OOR_IE = 6;
  localparam int CTL_SWSEQ = 7;
  localparam int CTL_CONT = 8;
  localparam int ST_OOR = 1;
  localparam int LIM_HI = 16;
  localparam int RES_VALID = 31;
  localparam logic [7:0] SAMPLE_RST = 8'h02;
  localparam logic [11:0] LIM_HI_RST = 12'hFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {REF_VDD, REF_VDD_HALF, REF_INT_1V024, REF_EXT} sarseq_ref_e;
  typedef enum {S_IDLE, S_SAMPLE, S_CONV} sarseq_state_e;
endpackage

/* File: verification/sar_adc_sequencer_control_test.sv */
/*
 sar_adc_sequencer_control_test: register-driven scenarios for the converter sequencer.
 Assumes sarseq_analog answers the comparator and the design asserts itself.
*/
`timescale 1ns/1ps
module sar_adc_sequencer_control_test;
  import sarseq_pkg::*;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [AW-1:0] awaddr = '0;
  logic [AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic lowpower = 1'h0;
  logic [SW_W-1:0] sw_user = '0;
  logic awready, wready, bvalid, arready, rvalid, comp, sample, temp_en, eoc, irq;
  logic [1:0] bresp, rresp, ref_sel, rd_resp, wr_resp;
  logic [31:0] rdata, rd_val;
  logic [RES_W-1:0] dac;
  logic [4:0] ch_sel;
  logic [SW_W-1:0] sw_ctrl;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int run = 0;
  int last_len = 0;
  int last_eoc = 0;
  int prev_eoc = 0;

  always #4 clk = ~clk;

  // aperture length and spacing of results
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    run <= sample ? run + 1 : 0;
    if (sample)
      last_len <= run + 1;
    if (eoc)
    begin
      prev_eoc <= last_eoc;
      last_eoc <= cyc;
    end
  end

  sarseq_ctrl DUT (.MCLK_IN(clk), .RESETN_IN(rstn), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .COMP_IN(comp), .LOWPOWER_IN(lowpower), .SW_USER_IN(sw_user), .DAC_CODE_OUT(dac), .SAMPLE_OUT(sample),
    .CH_SEL_OUT(ch_sel), .REF_SEL_OUT(ref_sel), .TEMP_EN_OUT(temp_en), .SW_CTRL_OUT(sw_ctrl),
    .EOC_OUT(eoc), .IRQ_OUT(irq));

  sarseq_analog analog (.ch_sel_in(ch_sel), .dac_code_in(dac), .temp_en_in(temp_en), .comp_out(comp));

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic give_up();
    failures++;
    test_done();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
      if (bvalid === 1'h1)
        break;
    end
    wr_resp = bresp;
    bready <= 1'h0;
    @(posedge clk);
    if (n == 100)
      give_up();
  endtask

  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] mask, input logic [31:0] exp);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (arready === 1'h1)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
        break;
    end
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'h0;
    @(posedge clk);
    if (n == 100)
      give_up();
    chk(rd_val & mask, exp);
  endtask

  task automatic wait_eoc();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (eoc !== 1'h1 && n < 2000);
    if (n == 2000)
      give_up();
  endtask

  task automatic conv(input logic [4:0] ch, input logic [31:0] ctl);
    wr(OFS_FWCH, {27'h0, ch});
    wr(OFS_CTRL, ctl | 32'h5);
    wait_eoc();
  endtask

  task automatic t_fw(input logic [4:0] ch, input logic [31:0] ctl, input logic [11:0] lvl);
    conv(ch, ctl);
    chk({20'h0, dac}, {20'h0, lvl});
    rdchk(9'h180 + {ch, 2'h0}, 32'h80000FFF, {20'h80000, lvl});
    rdchk(9'h180 + {ch, 2'h0}, 32'h80000000, 32'h0);
    rdchk(OFS_LAST, 32'h00000FFF, {20'h0, lvl});
  endtask

  task automatic t_reset();
    rdchk(OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rdchk(OFS_LIMIT, 32'hFFFFFFFF, 32'h0FFF0000);
    rdchk(9'h100, 32'h000000FF, 32'h2);
    rdchk(9'h01C, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    wr(OFS_LAST, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_ref();
    for (int r = 0; r < 4; r++)
    begin
      wr(OFS_CTRL, 32'(r) << CTL_REF);
      chk({30'h0, wr_resp}, {30'h0, RESP_OKAY});
      repeat (2) @(posedge clk);
      chk({30'h0, ref_sel}, 32'(r));
    end
  endtask

  // ch2 aperture 5 converter clocks; scan gap must be (5 + 18) * 7 clocks
  task automatic t_scan();
    wr(9'h104, 32'h1);
    wr(9'h108, 32'h5);
    wr(OFS_CHEN, 32'h6);
    wr(OFS_CTRL, 32'h7);
    wait_eoc();
    wait_eoc();
    @(posedge clk);
    chk(32'(last_len), 32'h23);
    chk(32'(last_eoc - prev_eoc), 32'hA1);
    rdchk(9'h184, 32'h80000FFF, 32'h8000015A);
    rdchk(9'h188, 32'h80000FFF, 32'h8000025A);
    rdchk(OFS_STATUS, 32'h1, 32'h0);
    wr(OFS_CTRL, 32'h107);
    repeat (3) wait_eoc();
    rdchk(OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_CTRL, 32'h0);
  endtask

  task automatic t_oor();
    wr(OFS_LIMIT, 32'h02000100);
    conv(5'h03, 32'h40);
    chk({31'h0, irq}, 32'h1);
    rdchk(OFS_STATUS, 32'h2, 32'h2);
    wr(OFS_STATUS, 32'h2);
    rdchk(OFS_STATUS, 32'h2, 32'h0);
    chk({31'h0, irq}, 32'h0);
    conv(5'h01, 32'h40);
    chk({31'h0, irq}, 32'h0);
    conv(5'h00, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdchk(OFS_STATUS, 32'h2, 32'h2);
    wr(OFS_STATUS, 32'h2);
    wr(OFS_LIMIT, 32'h0FFF0000);
  endtask

  task automatic t_lp();
    int n;
    lowpower <= 1'h1;
    repeat (4) @(posedge clk);
    rdchk(OFS_STATUS, 32'h80, 32'h80);
    wr(OFS_FWCH, 32'h3);
    wr(OFS_CTRL, 32'h5);
    n = 0;
    repeat (300)
    begin
      @(posedge clk);
      if (sample !== 1'h0 || eoc !== 1'h0)
        n++;
    end
    chk(32'(n), 32'h0);
    wr(OFS_CTRL, 32'h0);
    lowpower <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_sw();
    int n;
    sw_user <= 8'h01;
    wr(OFS_SWFW, 32'h80);
    repeat (2) @(posedge clk);
    chk({24'h0, sw_ctrl}, 32'h81);
    wr(OFS_FWCH, 32'h3);
    wr(OFS_CTRL, 32'h85);
    for (n = 0; n < 50 && sample !== 1'h1; n++)
      @(posedge clk);
    if (n == 50)
      give_up();
    chk({24'h0, sw_ctrl}, 32'h89);
    chk({27'h0, ch_sel}, 32'h3);
    wait_eoc();
    sw_user <= 8'h00;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    t_reset();
    t_ref();
    t_fw(5'h03, 32'h0, 12'h35A);
    t_fw(5'h09, 32'h20, 12'h95A);
    t_fw(TEMP_CH, 32'h0, 12'h7A3);
    t_scan();
    t_oor();
    t_lp();
    t_sw();
    test_done();
  end
endmodule // sar_adc_sequencer_control_test

/* File: verification/sarseq_analog.sv */
/*
 sarseq_analog: analog inputs, temperature sensor and comparator seen by the converter.
 Assumes each pin channel holds a fixed level; the sensor reads only while biased.
*/
`timescale 1ns/1ps
module sarseq_analog
  import sarseq_pkg::*;
(
  input wire logic [4:0] ch_sel_in,
  input wire logic [RES_W-1:0] dac_code_in,
  input wire logic temp_en_in,
  output logic comp_out
);
  logic [RES_W-1:0] level;

  always_comb
  begin
    level = {ch_sel_in[3:0], 8'h5A};
    if (ch_sel_in == TEMP_CH)
      level = temp_en_in ? 12'h7A3 : 12'h000;
    // unbiased sensor reads zero, so a missing bias shows in the result
    comp_out = level >= dac_code_in;
  end
endmodule // sarseq_analog
